// ==== core/spsc_link_front.sv ====
`default_nettype none
module spsc_link_front
  import spsc_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // pins
  input  wire logic serial_reset_pin,
  input  wire logic scl_in,
  input  wire logic sda_in,
  // gating from power logic
  input  wire logic link_enable,
  // results
  output logic      sda_pull,
  output logic      addr_match,
  output logic      link_reset
);

  spsc_link_st_t st;
  spsc_link_st_t next_st;

  // address decode, shared by ack and match flag
  function automatic logic is_our_addr(input logic [7:0] b);
    return b[7:1] == SPSC_DEV_ADDR7;
  endfunction : is_our_addr

  // serial-port reset detection and address-phase slave
  always_comb begin
    next_st = st;
    next_st.rst_sync = {st.rst_sync[0], serial_reset_pin};
    next_st.scl_sync = {st.scl_sync[1:0], scl_in};
    next_st.sda_sync = {st.sda_sync[1:0], sda_in};
    next_st.rst_prev = st.rst_sync[1];
    next_st.link_reset = 1'b0;
    // rising edge arms, falling edge fires the reset
    if (st.rst_sync[1] && !st.rst_prev) begin
      next_st.armed = 1'b1;
    end
    if (!st.rst_sync[1] && st.rst_prev && st.armed) begin
      next_st.armed      = 1'b0;
      next_st.link_reset = 1'b1;
    end
    if (st.rst_sync[1] || next_st.link_reset || !link_enable) begin
      // only the two-wire logic is cleared here
      next_st.in_frame  = 1'b0;
      next_st.bit_cnt   = 4'h0;
      next_st.shift     = 8'h00;
      next_st.addr_hit  = 1'b0;
      next_st.ack_drive = 1'b0;
    end else begin
      // start: sda falls while scl high
      if (st.scl_sync[2] && st.scl_sync[1] &&
          st.sda_sync[2] && !st.sda_sync[1]) begin
        next_st.in_frame  = 1'b1;
        next_st.bit_cnt   = 4'h0;
        next_st.addr_hit  = 1'b0;
        next_st.ack_drive = 1'b0;
      end else if (st.scl_sync[2] && st.scl_sync[1] &&
                   !st.sda_sync[2] && st.sda_sync[1]) begin
        next_st.in_frame  = 1'b0;
        next_st.ack_drive = 1'b0;
      end else if (st.in_frame && !st.scl_sync[2] && st.scl_sync[1]) begin
        // sample on scl rise
        if (st.bit_cnt < SPSC_ADDR_BITS) begin
          next_st.shift   = {st.shift[6:0], st.sda_sync[1]};
          next_st.bit_cnt = st.bit_cnt + 4'h1;
        end
      end else if (st.in_frame && st.scl_sync[2] && !st.scl_sync[1]) begin
        // scl fall: start or end the ack slot
        if (st.bit_cnt == SPSC_ADDR_BITS && !st.ack_drive &&
            !st.addr_hit) begin
          next_st.addr_hit  = is_our_addr(st.shift);
          next_st.ack_drive = is_our_addr(st.shift);
        end else if (st.ack_drive) begin
          next_st.ack_drive = 1'b0;
          next_st.in_frame  = 1'b0;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sda_pull   = st.ack_drive;
  assign addr_match = st.addr_hit;
  assign link_reset = st.link_reset;

endmodule : spsc_link_front
`default_nettype wire

// ==== core/spsc_pkg.sv ====
`default_nettype none
package spsc_pkg;

  // two-wire slave address, 8-bit form with write bit clear
  localparam logic [7:0] SPSC_DEV_ADDR_W = 8'h52;
  localparam logic [6:0] SPSC_DEV_ADDR7  = SPSC_DEV_ADDR_W[7:1];

  // clock and emitter timing
  localparam int unsigned SPSC_CLK_HZ        = 20000000;
  localparam int unsigned SPSC_EMIT_PERIOD_NS = 1000;
  localparam int unsigned SPSC_EMIT_HALF_CYC =
    (SPSC_EMIT_PERIOD_NS / 2) / (1000000000 / SPSC_CLK_HZ);
  localparam logic [7:0] SPSC_EMIT_CNT_RST = 8'h00;

  // power states
  typedef enum logic [1:0] {
    SPSC_PWR_BOOT    = 2'b00,
    SPSC_PWR_READY   = 2'b01,
    SPSC_PWR_RETAIN  = 2'b10,
    SPSC_PWR_RANGING = 2'b11
  } spsc_pwr_t;

  // host commands into the power logic
  typedef struct packed {
    logic go_ranging;
    logic go_ready;
    logic go_retain;
  } spsc_cmd_t;

  // open-drain pad: enable low means driving low
  typedef struct packed {
    logic o;
    logic oe_n;
  } spsc_od_t;

  // serial-port front end state
  typedef struct packed {
    logic [1:0] rst_sync;
    logic       rst_prev;
    logic       armed;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic       in_frame;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       addr_hit;
    logic       ack_drive;
    logic       link_reset;
  } spsc_link_st_t;

  localparam logic [3:0] SPSC_ADDR_BITS = 4'h8;

endpackage : spsc_pkg
`default_nettype wire

// ==== core/spsc_power_ctrl.sv ====
`default_nettype none
module spsc_power_ctrl
  import spsc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // host pins
  input  wire logic       serial_reset_pin,
  input  wire logic       comms_gate_pin_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_o,
  output logic            sda_oe_n,
  output logic            int_o,
  output logic            int_oe_n,
  output logic            spare_gpio_pin_o,
  output logic            spare_gpio_pin_oe_n,
  // core side
  input  wire spsc_cmd_t  cmd,
  input  wire logic       int_req,
  input  wire logic       spare_pull_req,
  input  wire logic       retain_we,
  input  wire logic [7:0] retain_wdata,
  // status
  output spsc_pwr_t       pwr_state,
  output logic            emitter_on,
  output logic            ranging_refused,
  output logic            link_reset_seen,
  output logic [7:0]      retain_data
);

  typedef struct packed {
    logic [1:0] gate_sync;
    spsc_pwr_t  pwr;
    logic [7:0] emit_cnt;
    logic       emit;
    logic       refused;
    logic       lreset;
    logic [7:0] retain;
    spsc_od_t   sda;
    spsc_od_t   intp;
    spsc_od_t   spare;
  } spsc_top_st_t;

  spsc_top_st_t st;
  spsc_top_st_t next_st;
  logic [1:0]   rst_sync;  // kept apart: reset by the raw pin
  logic         rst_n;
  logic         link_en;
  logic         sda_pull;
  logic         link_rst;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // gate blocks the link only in retained idle
  assign link_en = (st.pwr != SPSC_PWR_RETAIN) || st.gate_sync[1];

  spsc_link_front u_link (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .serial_reset_pin (serial_reset_pin),
    .scl_in           (scl_in),
    .sda_in           (sda_in),
    .link_enable      (link_en),
    .sda_pull         (sda_pull),
    .addr_match       (),
    .link_reset       (link_rst)
  );

  // power state machine and pads
  always_comb begin
    next_st = st;
    next_st.gate_sync = {st.gate_sync[0], comms_gate_pin_n};
    next_st.refused = 1'b0;
    next_st.lreset  = link_rst;
    case (st.pwr)
      SPSC_PWR_BOOT: begin
        next_st.pwr = SPSC_PWR_READY;
      end
      SPSC_PWR_READY: begin
        if (cmd.go_ranging) begin
          next_st.pwr = SPSC_PWR_RANGING;
        end else if (cmd.go_retain) begin
          next_st.pwr = SPSC_PWR_RETAIN;
        end
      end
      SPSC_PWR_RETAIN: begin
        if (cmd.go_ready) begin
          next_st.pwr = SPSC_PWR_READY;
        end else if (cmd.go_ranging) begin
          next_st.refused = 1'b1;
        end
      end
      SPSC_PWR_RANGING: begin
        if (cmd.go_ready) begin
          next_st.pwr = SPSC_PWR_READY;
        end
      end
      default: begin
        next_st.pwr = SPSC_PWR_READY;
      end
    endcase
    // retained contents frozen in retained idle
    if (retain_we && st.pwr != SPSC_PWR_RETAIN) begin
      next_st.retain = retain_wdata;
    end
    // emitter toggles only while ranging
    if (st.pwr == SPSC_PWR_RANGING) begin
      if (st.emit_cnt == 8'(SPSC_EMIT_HALF_CYC - 1)) begin
        next_st.emit_cnt = SPSC_EMIT_CNT_RST;
        next_st.emit     = ~st.emit;
      end else begin
        next_st.emit_cnt = st.emit_cnt + 8'h01;
      end
    end else begin
      next_st.emit_cnt = SPSC_EMIT_CNT_RST;
      next_st.emit     = 1'b0;
    end
    // open-drain pads: output always low, enable low pulls
    next_st.sda.o     = 1'b0;
    next_st.sda.oe_n  = ~sda_pull;
    next_st.intp.o    = 1'b0;
    next_st.intp.oe_n = ~int_req;
    next_st.spare.o    = 1'b0;
    next_st.spare.oe_n = ~spare_pull_req;
  end

  // state register; pads float after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st.gate_sync <= 2'b00;
      st.pwr       <= SPSC_PWR_BOOT;
      st.emit_cnt  <= SPSC_EMIT_CNT_RST;
      st.emit      <= 1'b0;
      st.refused   <= 1'b0;
      st.lreset    <= 1'b0;
      st.retain    <= 8'h00;
      st.sda       <= 2'b01;
      st.intp      <= 2'b01;
      st.spare     <= 2'b01;
    end else begin
      st.gate_sync <= next_st.gate_sync;
      st.pwr       <= next_st.pwr;
      st.emit_cnt  <= next_st.emit_cnt;
      st.emit      <= next_st.emit;
      st.refused   <= next_st.refused;
      st.lreset    <= next_st.lreset;
      st.retain    <= next_st.retain;
      st.sda       <= next_st.sda;
      st.intp      <= next_st.intp;
      st.spare     <= next_st.spare;
    end
  end

  assign sda_o               = st.sda.o;
  assign sda_oe_n            = st.sda.oe_n;
  assign int_o               = st.intp.o;
  assign int_oe_n            = st.intp.oe_n;
  assign spare_gpio_pin_o    = st.spare.o;
  assign spare_gpio_pin_oe_n = st.spare.oe_n;
  assign pwr_state           = st.pwr;
  assign emitter_on          = st.emit;
  assign ranging_refused     = st.refused;
  assign link_reset_seen     = st.lreset;
  assign retain_data         = st.retain;

endmodule : spsc_power_ctrl
`default_nettype wire

// ==== tb/spsc_host_model.sv ====
`default_nettype none
module spsc_host_model (
  // clock and device drive
  input  wire logic clk_sys,
  input  wire logic sda_o,
  input  wire logic sda_oe_n,
  // bus lines
  output var logic  scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_sda = 1'b1;
  initial scl = 1'b1;
  // pull-up: line low if either side pulls
  assign sda = host_sda & (sda_oe_n | sda_o);
  task automatic half;
    repeat (12) @(negedge clk_sys);
  endtask : half
  // start, address msb first, ack clock, stop
  task automatic send_addr(input logic [7:0] a, output logic ack);
    host_sda = 1'b0;
    half();
    for (int i = 8; i >= 0; i--) begin
      scl = 1'b0;
      host_sda = (i == 0) | a[7];
      a = a << 1;
      half();
      scl = 1'b1;
      ack = ~sda;
      half();
    end
    scl = 1'b0;
    host_sda = 1'b0;
    half();
    scl = 1'b1;
    half();
    host_sda = 1'b1;
    half();
  endtask : send_addr
endmodule : spsc_host_model
`default_nettype wire

// ==== tb/spsc_power_ctrl_assertions.sv ====
`default_nettype none
module spsc_power_ctrl_assertions
  import spsc_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rstn,
  // host and core requests
  input wire logic       serial_reset_pin,
  input wire spsc_cmd_t  cmd,
  input wire logic       int_req,
  input wire logic       spare_pull_req,
  input wire logic       retain_we,
  // pads
  input wire logic       int_o,
  input wire logic       int_oe_n,
  input wire logic       spare_gpio_pin_oe_n,
  // status
  input wire spsc_pwr_t  pwr_state,
  input wire logic       emitter_on,
  input wire logic       ranging_refused,
  input wire logic [7:0] retain_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // power command steps
  sequence s_run_req;
    pwr_state == SPSC_PWR_READY && cmd.go_ranging;
  endsequence
  sequence s_bad_req;
    pwr_state == SPSC_PWR_RETAIN && cmd.go_ranging && !cmd.go_ready;
  endsequence
  sequence s_wake_req;
    pwr_state == SPSC_PWR_RETAIN && cmd.go_ready && !cmd.go_ranging;
  endsequence
  chk_run_accept: assert property (
    s_run_req |=> pwr_state == SPSC_PWR_RANGING) else $error("run not taken");
  chk_run_refuse: assert property (
    s_bad_req |=> ranging_refused && pwr_state == SPSC_PWR_RETAIN)
    else $error("run not refused");
  chk_wake_ready: assert property (
    s_wake_req |=> pwr_state == SPSC_PWR_READY) else $error("no wake");
  chk_ready_hold: assert property (
    pwr_state == SPSC_PWR_READY && cmd == '0 |=> pwr_state == SPSC_PWR_READY)
    else $error("ready left");
  chk_boot_ready: assert property (
    $rose(rstn) |-> ##[1:6] pwr_state == SPSC_PWR_READY) else $error("no boot");
  chk_emit_idle: assert property (
    pwr_state != SPSC_PWR_RANGING && $past(pwr_state) != SPSC_PWR_RANGING
    |-> !emitter_on) else $error("emitter on in idle");
  chk_emit_pulse: assert property (
    pwr_state == SPSC_PWR_RANGING
    |-> ##[1:12] ($changed(emitter_on) || pwr_state != SPSC_PWR_RANGING))
    else $error("emitter stuck");
  chk_retain_hold: assert property (
    pwr_state == SPSC_PWR_RETAIN && $past(pwr_state) == SPSC_PWR_RETAIN
    |-> $stable(retain_data)) else $error("retained data changed");
  chk_int_pull: assert property (
    int_req |=> !int_oe_n && !int_o) else $error("int not pulled");
  chk_spare_float: assert property (
    !spare_pull_req |=> spare_gpio_pin_oe_n) else $error("spare not floating");
  chk_link_keep: assert property (
    serial_reset_pin && cmd == '0 && !retain_we
    |=> $stable(pwr_state) && $stable(retain_data)) else $error("core hit");
endmodule : spsc_power_ctrl_assertions

bind spsc_power_ctrl spsc_power_ctrl_assertions chk (.*);
`default_nettype wire

// ==== tb/spsc_power_ctrl_bench.sv ====
`default_nettype none
module spsc_power_ctrl_bench
  import spsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam spsc_cmd_t RUN_C = 3'b100;
  localparam spsc_cmd_t RDY_C = 3'b010;
  localparam spsc_cmd_t RET_C = 3'b001;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       serial_reset_pin = 1'b0;
  logic       comms_gate_pin_n = 1'b1;
  logic       int_req = 1'b0;
  logic       spare_pull_req = 1'b0;
  logic       retain_we = 1'b0;
  logic [7:0] retain_wdata = 8'h00;
  spsc_cmd_t  cmd = '0;
  logic       scl, sda, sda_o, sda_oe_n, int_o, int_oe_n, ack, seen;
  logic       spare_gpio_pin_o, spare_gpio_pin_oe_n;
  spsc_pwr_t  pwr_state;
  logic       emitter_on, ranging_refused, link_reset_seen;
  logic [7:0] retain_data;
  int         mismatches = 0;
  int         checks_done = 0;
  int         cycles = 0;
  always #25 clk_sys = ~clk_sys;
  spsc_power_ctrl uut (.scl_in(scl), .sda_in(sda), .*);
  spsc_host_model host (.*);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic ck_st(input spsc_pwr_t s);
    check({6'h00, pwr_state}, {6'h00, s});
  endtask : ck_st
  // one-cycle command, catching the refusal pulse
  task automatic pulse_cmd(input spsc_cmd_t c);
    cmd = c;
    tick(1);
    cmd = '0;
    seen = ranging_refused;
    tick(1);
  endtask : pulse_cmd
  task automatic wr(input logic [7:0] d);
    retain_wdata = d;
    retain_we = 1'b1;
    tick(1);
    retain_we = 1'b0;
  endtask : wr
  task automatic t_pins;
    check({6'h00, int_oe_n, spare_gpio_pin_oe_n}, 8'h03);
    check({6'h00, sda_oe_n, sda_o}, 8'h02);
    ck_st(SPSC_PWR_READY);
    int_req = 1'b1;
    spare_pull_req = 1'b1;
    tick(2);
    check({6'h00, int_oe_n, int_o}, 8'h00);
    check({6'h00, spare_gpio_pin_oe_n, spare_gpio_pin_o}, 8'h00);
    int_req = 1'b0;
    spare_pull_req = 1'b0;
    tick(20);
    check({6'h00, int_oe_n, spare_gpio_pin_oe_n}, 8'h03);
    ck_st(SPSC_PWR_READY);
    $display("pins test done");
  endtask : t_pins
  task automatic t_run;
    int n = 0;
    pulse_cmd(RUN_C);
    ck_st(SPSC_PWR_RANGING);
    for (int i = 0; i < 40; i++) begin
      seen = emitter_on;
      tick(1);
      n += int'(seen != emitter_on);
    end
    check(8'(n), 8'h04);
    pulse_cmd(RDY_C);
    ck_st(SPSC_PWR_READY);
    check({7'h00, emitter_on}, 8'h00);
    $display("ranging test done");
  endtask : t_run
  task automatic t_retain;
    wr(8'ha5);
    pulse_cmd(RET_C);
    ck_st(SPSC_PWR_RETAIN);
    wr(8'h3c);
    pulse_cmd(RUN_C);
    check({6'h00, seen, pwr_state == SPSC_PWR_RETAIN}, 8'h03);
    comms_gate_pin_n = 1'b0;
    tick(4);
    host.send_addr(SPSC_DEV_ADDR_W, ack);
    check({7'h00, ack}, 8'h00);
    comms_gate_pin_n = 1'b1;
    tick(4);
    host.send_addr(SPSC_DEV_ADDR_W, ack);
    check({7'h00, ack}, 8'h01);
    pulse_cmd(RDY_C);
    ck_st(SPSC_PWR_READY);
    check(retain_data, 8'ha5);
    $display("retain test done");
  endtask : t_retain
  task automatic t_addr;
    logic [7:0] a[3] = '{SPSC_DEV_ADDR_W, SPSC_DEV_ADDR_W | 8'h01, 8'h54};
    for (int i = 0; i < 3; i++) begin
      host.send_addr(a[i], ack);
      check({7'h00, ack}, {7'h00, i < 2});
    end
    $display("address test done");
  endtask : t_addr
  task automatic t_link;
    pulse_cmd(RUN_C);
    wr(8'h5a);
    serial_reset_pin = 1'b1;
    tick(6);
    serial_reset_pin = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 12; i++) begin
      tick(1);
      seen |= link_reset_seen;
    end
    check({7'h00, seen}, 8'h01);
    ck_st(SPSC_PWR_RANGING);
    check(retain_data, 8'h5a);
    host.send_addr(SPSC_DEV_ADDR_W, ack);
    check({7'h00, ack}, 8'h01);
    pulse_cmd(RDY_C);
    $display("serial reset test done");
  endtask : t_link
  // cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    tick(4);
    rstn = 1'b1;
    tick(8);
    t_pins();
    t_run();
    t_retain();
    t_addr();
    t_link();
    end_of_test();
  end
endmodule : spsc_power_ctrl_bench
`default_nettype wire
